// ---- rtl/ctc_pkg.sv ----
package ctc_pkg;

  // ************************************************************
  // Register indices
  // ************************************************************
  localparam logic [4:0] OFS_STAT = 5'h0d;
  localparam logic [4:0] OFS_XFER = 5'h0e;
  localparam logic [4:0] OFS_SIZE = 5'h0f;
  localparam logic [4:0] OFS_FLAG = 5'h10;
  localparam logic [4:0] OFS_MH   = 5'h11;
  localparam logic [4:0] OFS_SM   = 5'h12;
  localparam logic [4:0] OFS_HD   = 5'h13;
  localparam logic [4:0] OFS_MY   = 5'h14;
  localparam logic [4:0] OFS_WD   = 5'h15;

  // ************************************************************
  // Field positions and codes
  // ************************************************************
  localparam int BIT_UP   = 0;
  localparam int BIT_DN   = 1;
  localparam int BIT_CMP  = 2;
  localparam int BIT_RES  = 3;
  localparam int BIT_ERR  = 12;
  localparam int BIT_FLG  = 11;
  localparam int BIT_ADJ  = 13;
  localparam int BIT_STOP = 14;
  localparam logic [7:0] SIZE_NONE = 8'h00;
  localparam logic [7:0] SIZE_SMALL = 8'h04;
  localparam logic [7:0] SIZE_LARGE = 8'h08;
  localparam logic [3:0] TYPE_NONE = 4'h0;
  localparam logic [3:0] TYPE_EE4K = 4'h1;
  localparam logic [7:0] BCD_HALF = 8'h30;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONE  = 8'h01;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES   = CLK_HZ * TICK_PERIOD_S;
  localparam logic [1:0] ARM_CYCLES = 2'h3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_CMP} ctc_state_t;

  typedef struct packed {
    logic       present;
    logic       clkFit;
    logic       wrProt;
    logic       autoSw;
    logic [3:0] kind;
  } ctc_pins_t;

  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ctc_bus_t;

  typedef struct packed {
    logic       opDone;
    logic       cmpDiff;
    logic       progMode;
    logic [7:0] cassCode;
    logic [7:0] cpuCode;
  } ctc_eng_t;

  typedef struct packed {
    logic cfgCsum;
    logic progCsum;
    logic badInstr;
    logic tblCsum;
    logic bootFail;
  } ctc_evt_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hour;
    logic [7:0] day;
    logic [7:0] mon;
    logic [7:0] year;
    logic [7:0] wday;
  } ctc_time_t;

endpackage : ctc_pkg

// ---- rtl/ctc_bank.sv ----
`timescale 1ns/10ps
module ctc_bank
  import ctc_pkg::*;
#(
  parameter int TICK = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register port
  input  wire ctc_bus_t    bus,
  output logic [15:0]      rdata,
  // Cassette pins
  input  wire ctc_pins_t   pins,
  // Transfer engine
  input  wire ctc_eng_t    eng,
  output logic             opStart,
  output logic [1:0]       opKind,
  // Integrity events and restore commands
  input  wire ctc_evt_t    evt,
  output logic             cfgRestore,
  output logic             tblRestore
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    ctc_state_t  fsm;
    logic [2:0]  req;
    logic        cmpRes;
    logic [3:0]  err;
    logic [4:0]  flag;
    ctc_pins_t   s1;
    ctc_pins_t   s2;
    ctc_pins_t   s3;
    ctc_pins_t   filt;
    logic        armed;
    logic [1:0]  armCnt;
    ctc_time_t   tm;
    logic [24:0] tickCnt;
    logic        adj;
    logic        stop;
    logic        start;
    logic [1:0]  kind;
    logic        cfgRst;
    logic        tblRst;
    logic [15:0] rdata;
  } ctc_st_t;

  ctc_st_t st_r;
  ctc_st_t st_nxt;

  function automatic logic [7:0] bcdInc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      return {v[7:4] + 4'h1, 4'h0};
    end
    return v + 8'h01;
  endfunction : bcdInc

  function automatic logic [7:0] monthLen(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction : monthLen

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic        wrX;
    logic        wrW;
    logic        carry;
    logic        noCass;
    logic [15:0] rd;
    st_nxt = st_r;
    wrX = bus.wr && bus.addr == OFS_XFER;
    wrW = bus.wr && bus.addr == OFS_WD;
    carry = 1'b0;
    noCass = st_r.filt.kind == TYPE_NONE || !st_r.filt.present;
    rd = 16'h0000;
    st_nxt.start = 1'b0;
    st_nxt.cfgRst = 1'b0;
    st_nxt.tblRst = 1'b0;

    // Pins are only trusted once two late stages agree.
    st_nxt.s1 = pins;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.filt = st_r.s3;
    end
    if (!st_r.armed) begin
      st_nxt.armCnt = st_r.armCnt + 2'h1;
      st_nxt.armed = st_r.armCnt == ARM_CYCLES;
    end

    case (st_r.fsm)
      ST_IDLE: begin
        if (wrX && (bus.wdata[BIT_UP] || bus.wdata[BIT_DN])) begin
          st_nxt.req[1:0] = bus.wdata[BIT_DN] && !bus.wdata[BIT_UP] ? 2'b10 : 2'b01;
          st_nxt.kind = bus.wdata[BIT_UP] ? 2'h0 : 2'h1;
          if (eng.progMode) begin
            st_nxt.err[0] = 1'b1;
            st_nxt.req[1:0] = 2'b00;
          end else if (bus.wdata[BIT_DN] && !bus.wdata[BIT_UP] && (noCass || eng.cassCode == SIZE_NONE)) begin
            st_nxt.err[3] = 1'b1;
            st_nxt.req[1:0] = 2'b00;
          end else if (bus.wdata[BIT_UP] && st_r.filt.wrProt) begin
            st_nxt.err[1] = 1'b1;
            st_nxt.req[1:0] = 2'b00;
          end else if (bus.wdata[BIT_UP] &&
                       (noCass || (st_r.filt.kind == TYPE_EE4K && eng.cpuCode == SIZE_LARGE))) begin
            st_nxt.err[2] = 1'b1;
            st_nxt.req[1:0] = 2'b00;
          end else begin
            st_nxt.start = 1'b1;
            st_nxt.fsm = ST_XFER;
          end
        end else if (wrX && bus.wdata[BIT_CMP]) begin
          if (noCass || eng.cassCode == SIZE_NONE) begin
            st_nxt.cmpRes = 1'b1;
          end else begin
            st_nxt.req[2] = 1'b1;
            st_nxt.kind = 2'h2;
            st_nxt.start = 1'b1;
            st_nxt.fsm = ST_CMP;
          end
        end
      end
      ST_XFER: begin
        if (eng.opDone) begin
          st_nxt.req[1:0] = 2'b00;
          st_nxt.fsm = ST_IDLE;
        end
      end
      ST_CMP: begin
        if (eng.opDone) begin
          st_nxt.req[2] = 1'b0;
          st_nxt.cmpRes = eng.cmpDiff;
          st_nxt.fsm = ST_IDLE;
        end
      end
      default: begin
        st_nxt.fsm = ST_IDLE;
      end
    endcase

    // Error bits clear on a one written, unless that bit newly sets the same cycle.
    if (wrX) begin
      st_nxt.err = st_nxt.err & ~(bus.wdata[15:12] & ~(st_nxt.err ^ st_r.err));
    end

    if (evt.cfgCsum) begin
      st_nxt.flag[0] = 1'b1;
      st_nxt.cfgRst = 1'b1;
    end
    if (evt.progCsum || evt.badInstr) begin
      st_nxt.flag[1] = 1'b1;
    end
    if (evt.tblCsum) begin
      st_nxt.flag[2] = 1'b1;
      st_nxt.tblRst = 1'b1;
    end
    if (st_r.armed && st_nxt.filt.present && !st_r.filt.present) begin
      st_nxt.flag[3] = 1'b1;
    end
    if (evt.bootFail && st_r.filt.autoSw) begin
      st_nxt.flag[4] = 1'b1;
    end

    if (wrW) begin
      st_nxt.adj = bus.wdata[BIT_ADJ];
      st_nxt.stop = bus.wdata[BIT_STOP];
    end
    st_nxt.tickCnt = st_r.tickCnt == 25'(TICK - 1) ? 25'h0000000 : st_r.tickCnt + 25'h0000001;
    if (st_r.filt.clkFit && !st_r.stop) begin
      if (st_r.adj) begin
        // A fresh adjust written in the same cycle is kept rather than lost.
        st_nxt.adj = wrW && bus.wdata[BIT_ADJ];
        st_nxt.tm.sec = RST_ZERO;
        carry = st_r.tm.sec >= BCD_HALF;
        st_nxt.tickCnt = 25'h0000000;
      end else if (st_r.tickCnt == 25'(TICK - 1)) begin
        carry = st_r.tm.sec == 8'h59;
        st_nxt.tm.sec = carry ? RST_ZERO : bcdInc(st_r.tm.sec);
      end
      if (carry) begin
        carry = st_r.tm.min == 8'h59;
        st_nxt.tm.min = carry ? RST_ZERO : bcdInc(st_r.tm.min);
      end
      if (carry) begin
        carry = st_r.tm.hour == 8'h23;
        st_nxt.tm.hour = carry ? RST_ZERO : bcdInc(st_r.tm.hour);
      end
      if (carry) begin
        st_nxt.tm.wday = st_r.tm.wday == 8'h06 ? RST_ZERO : bcdInc(st_r.tm.wday);
        carry = st_r.tm.day == monthLen(st_r.tm.mon, st_r.tm.year);
        st_nxt.tm.day = carry ? RST_ONE : bcdInc(st_r.tm.day);
      end
      if (carry) begin
        carry = st_r.tm.mon == 8'h12;
        st_nxt.tm.mon = carry ? RST_ONE : bcdInc(st_r.tm.mon);
      end
      if (carry) begin
        st_nxt.tm.year = st_r.tm.year == 8'h99 ? RST_ZERO : bcdInc(st_r.tm.year);
      end
    end

    // ************************************************************
    // Read mux
    // ************************************************************
    case (bus.addr)
      OFS_STAT: rd = {8'h00, st_r.filt.kind, 1'b0, st_r.filt.wrProt, st_r.filt.clkFit, st_r.filt.present};
      OFS_XFER: rd = {st_r.err, 8'h00, st_r.cmpRes, st_r.req};
      OFS_SIZE: rd = {eng.cpuCode, noCass ? SIZE_NONE : eng.cassCode};
      OFS_FLAG: rd = {st_r.flag, 11'h000};
      OFS_MH:   rd = {st_r.tm.hour, st_r.tm.min};
      OFS_SM:   rd = {st_r.tm.min, st_r.tm.sec};
      OFS_HD:   rd = {st_r.tm.day, st_r.tm.hour};
      OFS_MY:   rd = {st_r.tm.year, st_r.tm.mon};
      OFS_WD:   rd = {1'b0, st_r.stop, st_r.adj, 5'h00, st_r.tm.wday};
      default:  rd = 16'h0000;
    endcase
    if (!st_r.filt.clkFit && bus.addr >= OFS_MH) begin
      rd = 16'h0000;
    end
    st_nxt.rdata = bus.rd ? rd : 16'h0000;
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
      st_r.tm.day <= RST_ONE;
      st_r.tm.mon <= RST_ONE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign opStart = st_r.start;
  assign opKind = st_r.kind;
  assign cfgRestore = st_r.cfgRst;
  assign tblRestore = st_r.tblRst;

  // ************************************************************
  // Checks
  // ************************************************************
  // transfer self-clear
  property p_xferClr;
    @(posedge mclk) disable iff (rst) st_r.fsm == ST_XFER && eng.opDone |=> st_r.req[1:0] == 2'b00;
  endproperty
  a_xferClr: assert property (p_xferClr) else $error("request bit not cleared");

  property p_modeErr;
    @(posedge mclk) disable iff (rst)
      st_r.fsm == ST_IDLE && bus.wr && bus.addr == OFS_XFER && bus.wdata[BIT_UP] && eng.progMode
      |=> st_r.err[0] && st_r.fsm == ST_IDLE && !opStart;
  endproperty
  a_modeErr: assert property (p_modeErr) else $error("mode refusal missing");

  property p_cmpBusy;
    @(posedge mclk) disable iff (rst) st_r.fsm == ST_CMP |-> st_r.req[2];
  endproperty
  a_cmpBusy: assert property (p_cmpBusy) else $error("compare bit low while busy");

  property p_cmpRes;
    @(posedge mclk) disable iff (rst) st_r.fsm == ST_CMP && eng.opDone
      |=> st_r.cmpRes == $past(eng.cmpDiff) && !st_r.req[2];
  endproperty
  a_cmpRes: assert property (p_cmpRes) else $error("compare result wrong");

  property p_hotIns;
    @(posedge mclk) disable iff (rst) $past(st_r.armed) && $rose(st_r.filt.present) |-> st_r.flag[3];
  endproperty
  a_hotIns: assert property (p_hotIns) else $error("insertion flag missing");

  property p_bootErr;
    @(posedge mclk) disable iff (rst) evt.bootFail && st_r.filt.autoSw |=> st_r.flag[4];
  endproperty
  a_bootErr: assert property (p_bootErr) else $error("autoload flag missing");

  property p_tblRst;
    @(posedge mclk) disable iff (rst) evt.tblCsum |=> tblRestore ##1 !tblRestore || $past(evt.tblCsum);
  endproperty
  a_tblRst: assert property (p_tblRst) else $error("table restore wrong");

  property p_stopHold;
    @(posedge mclk) disable iff (rst) st_r.stop && !(bus.wr && bus.addr == OFS_WD) |=> $stable(st_r.tm);
  endproperty
  a_stopHold: assert property (p_stopHold) else $error("clock moved while stopped");

  property p_sizeNone;
    @(posedge mclk) disable iff (rst) bus.rd && bus.addr == OFS_SIZE && !st_r.filt.present |=> rdata[7:0] == SIZE_NONE;
  endproperty
  a_sizeNone: assert property (p_sizeNone) else $error("size code without cassette");

  property p_protErr;
    @(posedge mclk) disable iff (rst)
      st_r.fsm == ST_IDLE && bus.wr && bus.addr == OFS_XFER && bus.wdata[BIT_UP]
      && !eng.progMode && st_r.filt.wrProt |=> st_r.err[1] && !opStart;
  endproperty
  a_protErr: assert property (p_protErr) else $error("protect refusal missing");

  property p_cfgRst;
    @(posedge mclk) disable iff (rst) evt.cfgCsum |=> st_r.flag[0] && cfgRestore;
  endproperty
  a_cfgRst: assert property (p_cfgRst) else $error("settings restore missing");

  property p_progBad;
    @(posedge mclk) disable iff (rst) evt.progCsum || evt.badInstr |=> st_r.flag[1];
  endproperty
  a_progBad: assert property (p_progBad) else $error("program invalid flag missing");

endmodule : ctc_bank

// ---- sim/ctc_cass_model.sv ----
`timescale 1ns/10ps
module ctc_cass_model
  import ctc_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Engine requests
  input  wire logic       opStart,
  input  wire logic [1:0] opKind,
  // Scenario control
  input  wire ctc_pins_t  fitPins,
  input  wire logic       slow,
  input  wire logic       diff,
  // Toward the bank
  output ctc_pins_t       pins,
  output logic            opDone,
  output logic            cmpDiff
);
  logic [3:0] cnt_r;
  logic       isCmp_r;

  assign pins = fitPins;

  // one done pulse
  // The result line carries junk outside the done pulse, so a bank that samples it late is caught.
  always_ff @(posedge mclk) begin
    if (rst) begin
      cnt_r   <= 4'h0;
      isCmp_r <= 1'b0;
      opDone  <= 1'b0;
      cmpDiff <= 1'b0;
    end else begin
      opDone  <= 1'b0;
      cmpDiff <= ~diff;
      if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          opDone  <= 1'b1;
          cmpDiff <= isCmp_r & diff;
        end
      end else if (opStart) begin
        cnt_r   <= slow ? 4'hc : 4'h2;
        isCmp_r <= (opKind == 2'h2);
      end
    end
  end
endmodule : ctc_cass_model

// ---- sim/tb_cassette_transfer_and_clock_status.sv ----
`timescale 1ns/10ps
module tb_cassette_transfer_and_clock_status;
  import ctc_pkg::*;
  localparam int TICK = 20;
  logic mclk, rst, opStart, opDone, cmpDiff, cfgRestore, tblRestore, slow, diff, progMode;
  logic [1:0]  opKind;
  logic [15:0] rdata;
  logic [7:0]  cassCode, cpuCode;
  ctc_bus_t    bus;
  ctc_pins_t   fitPins, pins;
  ctc_evt_t    evt;
  ctc_eng_t    eng;
  int          errors, tests_run, cyc;

  assign eng = '{opDone: opDone, cmpDiff: cmpDiff, progMode: progMode, cassCode: cassCode, cpuCode: cpuCode};

  ctc_bank #(.TICK(TICK)) dut (.mclk(mclk), .rst(rst), .bus(bus), .rdata(rdata), .pins(pins), .eng(eng),
    .opStart(opStart), .opKind(opKind), .evt(evt), .cfgRestore(cfgRestore), .tblRestore(tblRestore));
  ctc_cass_model cass (.mclk(mclk), .rst(rst), .opStart(opStart), .opKind(opKind), .fitPins(fitPins),
    .slow(slow), .diff(diff), .pins(pins), .opDone(opDone), .cmpDiff(cmpDiff));

  // ************************************************************
  // Bus and check helpers
  // ************************************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd

  task automatic pinsSet(input ctc_pins_t p);
    @(posedge mclk);
    fitPins <= p;
    repeat (8) @(posedge mclk);
  endtask : pinsSet

  // Polls the transfer word until the given bits drop, so a hung engine ends in a mismatch.
  task automatic waitIdle(input logic [15:0] mask, output logic [15:0] d);
    int n;
    n = 0;
    do begin
      rd(OFS_XFER, d);
      n++;
    end while ((d & mask) !== 16'h0000 && n < 40);
  endtask : waitIdle

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset;
    logic [15:0] d;
    rd(OFS_XFER, d);
    chk(d, 16'h0000);
    rd(OFS_SIZE, d);
    chk(d, 16'h0400);
    rd(OFS_FLAG, d);
    chk(d, 16'h0000);
    for (int a = 17; a <= 21; a++) begin
      rd(a[4:0], d);
      chk(d, 16'h0000);
    end
    rd(5'h00, d);
    chk(d, 16'h0000);
    pinsSet('{present: 1'b1, clkFit: 1'b0, wrProt: 1'b0, autoSw: 1'b1, kind: 4'h2});
    rd(OFS_FLAG, d);
    chk(d, 16'h4000);
    $display("test reset and insertion done");
  endtask : t_reset

  task automatic t_types;
    logic [15:0] d;
    logic [3:0]  k [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
    for (int i = 0; i < 4; i++) begin
      pinsSet('{present: 1'b1, clkFit: 1'b0, wrProt: 1'b1, autoSw: 1'b1, kind: k[i]});
      rd(OFS_STAT, d);
      chk(d, {8'h00, k[i], 4'h5});
    end
    $display("test cassette types done");
  endtask : t_types

  task automatic t_move(input logic [15:0] req, input logic [1:0] kind);
    logic [15:0] d;
    pinsSet('{present: 1'b1, clkFit: 1'b0, wrProt: 1'b0, autoSw: 1'b1, kind: 4'h2});
    slow <= 1'b1;
    wr(OFS_XFER, req);
    chk({15'h0, opStart}, 16'h0001);
    chk({14'h0, opKind}, {14'h0, kind});
    rd(OFS_XFER, d);
    chk(d, req);
    waitIdle(req, d);
    chk(d, 16'h0000);
    $display("test transfer %0d done", kind);
  endtask : t_move

  task automatic t_cmp(input logic dv);
    logic [15:0] d;
    diff <= dv;
    wr(OFS_XFER, 16'h0004);
    rd(OFS_XFER, d);
    chk(d & 16'h0004, 16'h0004);
    waitIdle(16'h0004, d);
    chk(d, {12'h0, dv, 3'h0});
    $display("test compare %0d done", dv);
  endtask : t_cmp

  task automatic t_err(input logic pm, input logic wp, input logic [3:0] k, input logic [7:0] cc,
                       input logic [7:0] pc, input logic [15:0] req, input logic [15:0] bitv);
    logic [15:0] d;
    progMode <= pm;
    cassCode <= cc;
    cpuCode  <= pc;
    pinsSet('{present: 1'b1, clkFit: 1'b0, wrProt: wp, autoSw: 1'b1, kind: k});
    wr(OFS_XFER, req);
    chk({15'h0, opStart}, 16'h0000);
    rd(OFS_XFER, d);
    chk(d, bitv);
    wr(OFS_XFER, 16'hf000);
    rd(OFS_XFER, d);
    chk(d, 16'h0000);
    progMode <= 1'b0;
    cassCode <= 8'h04;
    cpuCode  <= 8'h04;
    $display("test refusal %h done", bitv);
  endtask : t_err

  task automatic t_evt;
    logic [15:0] d;
    ctc_evt_t    e [5] = '{5'h10, 5'h04, 5'h02, 5'h01, 5'h08};
    logic [15:0] f [5] = '{16'h4800, 16'h5800, 16'h7800, 16'hf800, 16'hf800};
    for (int i = 0; i < 5; i++) begin
      @(posedge mclk);
      evt <= e[i];
      @(posedge mclk);
      evt <= '0;
      #1;
      chk({14'h0, cfgRestore, tblRestore}, {14'h0, e[i].cfgCsum, e[i].tblCsum});
      rd(OFS_FLAG, d);
      chk(d, f[i]);
    end
    $display("test integrity flags done");
  endtask : t_evt

  // A cassette already present at reset release must not count as an insertion.
  task automatic t_rst2;
    logic [15:0] d;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd(OFS_FLAG, d);
    chk(d, 16'h0000);
    pinsSet('{present: 1'b1, clkFit: 1'b0, wrProt: 1'b0, autoSw: 1'b0, kind: 4'h2});
    @(posedge mclk);
    evt <= 5'h01;
    @(posedge mclk);
    evt <= 5'h08;
    @(posedge mclk);
    evt <= '0;
    rd(OFS_FLAG, d);
    chk(d, 16'h1000);
    $display("test mid-run reset done");
  endtask : t_rst2

  task automatic t_clock;
    logic [15:0] a, b;
    int          n;
    pinsSet('{present: 1'b1, clkFit: 1'b1, wrProt: 1'b0, autoSw: 1'b1, kind: 4'h2});
    rd(OFS_SM, a);
    n = 0;
    do begin
      rd(OFS_SM, b);
      n++;
    end while (b === a && n < 20);
    repeat (10 * TICK) @(posedge mclk);
    rd(OFS_SM, a);
    chk(a, {b[15:8], b[7:4] + 4'h1, b[3:0]});
    rd(OFS_MH, a);
    chk(a, 16'h0000);
    rd(OFS_HD, a);
    chk(a, 16'h0100);
    rd(OFS_MY, a);
    chk(a, 16'h0001);
    wr(OFS_WD, 16'h4000);
    rd(OFS_WD, a);
    chk(a, 16'h4000);
    rd(OFS_SM, b);
    repeat (3 * TICK) @(posedge mclk);
    rd(OFS_SM, a);
    chk(a, b);
    wr(OFS_WD, 16'h0000);
    n = 0;
    do begin
      rd(OFS_SM, a);
      n++;
    end while (a[7:0] < BCD_HALF && n < 400);
    wr(OFS_WD, 16'h2000);
    rd(OFS_SM, a);
    chk(a, 16'h0100);
    rd(OFS_WD, a);
    chk(a, 16'h0000);
    repeat (5 * TICK) @(posedge mclk);
    wr(OFS_WD, 16'h2000);
    rd(OFS_SM, a);
    chk(a, 16'h0100);
    $display("test calendar clock done");
  endtask : t_clock

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end

  initial begin
    errors = 0;
    tests_run = 0;
    cyc = 0;
    rst = 1'b1;
    bus = '0;
    evt = '0;
    fitPins = '0;
    slow = 1'b0;
    diff = 1'b0;
    progMode = 1'b0;
    cassCode = 8'h04;
    cpuCode = 8'h04;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_types();
    t_move(16'h0001, 2'h0);
    t_move(16'h0002, 2'h1);
    t_cmp(1'b1);
    t_cmp(1'b0);
    t_err(1'b1, 1'b0, 4'h2, 8'h04, 8'h04, 16'h0001, 16'h1000);
    t_err(1'b0, 1'b1, 4'h2, 8'h04, 8'h04, 16'h0001, 16'h2000);
    t_err(1'b0, 1'b0, 4'h1, 8'h04, 8'h08, 16'h0001, 16'h4000);
    t_err(1'b0, 1'b0, 4'h2, 8'h00, 8'h04, 16'h0002, 16'h8000);
    t_evt();
    t_rst2();
    t_clock();
    end_sim();
  end
endmodule : tb_cassette_transfer_and_clock_status
